/* File: inc/coef_defs.vh */
// Constants shared by the coefficient access port and the equaliser engine
// Behaviour
// - 69 x 20-bit store, indirect access only
// - Low data register holds low sixteen bits
// - Control low nibble holds upper bits
// - Read bit selects fetch or store
// - Only a control write starts access
// - Low data bytes: even 15:8, odd 7:0
// - Redirection only while 72h bit 0 set
// - Each channel scaled into subwoofer sum
// - Four biquads; shared LR, shared surround
// - Input scale factor before each filter chain
// - Filters active only when 70h enables
// - Side-firing feeds half the surround difference through the surround filters
// - Centre and LFE only with six channels
// - Even byte high, odd byte low
// - Five terms per stage, filters 0..3
`ifndef COEF_DEFS_VH
`define COEF_DEFS_VH
`define COEF_W        20
`define COEF_N        8'd69
`define COEF_AW       7
`define HIST_N        80
`define HIST_AW       7
`define HIST_LAST     7'd79
`define SMP_W         24
`define PROD_W        44
`define ACC_W         48
`define FRAC          19
`define REG_W         16
`define REG_RST       16'h0000
`define A_RESET       8'h00
`define A_EQ          8'h70
`define A_BASS        8'h72
`define A_DATA        8'h78
`define A_CTRL        8'h7A
`define EQ_EN_BIT     0
`define SF_EN_BIT     1
`define BASS_EN_BIT   0
`define RD_BIT        4
`define IDX_BASE      8'h40
`define IDX_SUB0      7'h28
`define IDX_SUB1      7'h29
`define IDX_SUB2      7'h2A
`define IDX_SUB3      7'h2B
`define IDX_SUB4      7'h2C
`define IDX_SCALE_LR  7'h3C
`define IDX_SCALE_SUR 7'h3D
`define IDX_SCALE_SUB 7'h3E
`define IDX_RED       7'h3F
`define IDX_RED_LFE   7'h44
`define GRP_LR        7'h00
`define GRP_SUR       7'h14
`define GRP_SUB       7'h28
`define STAGE_TERMS   7'd5
`define STAGE_LAST    2'd3
`define TERMS         3'd5
`define WB_LAST       3'd3
`define RED_N         3'd6
`define SL_X1         2'd0
`define SL_X2         2'd1
`define SL_Y1         2'd2
`define SL_Y2         2'd3
`define DEF_SUB0      20'h00032
`define DEF_SUB1      20'h80032
`define DEF_SUB2      20'h7C7EA
`define DEF_SUB3      20'h81C6F
`define DEF_SCALE     20'h80000
`define DEF_RED       20'hC0000
`define DEF_ZERO      20'h00000
`define SMP_MAX       24'h7FFFFF
`define SMP_MIN       24'h800000
`endif

/* File: design/dual_ram.v */
// Two-port RAM with registered read data on both ports
`timescale 1ns/1ps
`default_nettype none
module dual_ram #(
    parameter W  = 20,
    parameter D  = 69,
    parameter AW = 7
) (
    // Clock
    input  wire          clk,
    // Read-write port
    input  wire          a_we,
    input  wire [AW-1:0] a_addr,
    input  wire [W-1:0]  a_wdata,
    output reg  [W-1:0]  a_rdata,
    // Read-only port
    input  wire [AW-1:0] b_addr,
    output reg  [W-1:0]  b_rdata
);
    reg [W-1:0] mem [0:D-1];

    always @(posedge clk) begin
        if (a_we)
            mem[a_addr] <= a_wdata;
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule // dual_ram
`default_nettype wire

/* File: design/eq_coefficient_access.v */
// Coefficient store access registers and the equaliser / bass redirection engine
`timescale 1ns/1ps
`default_nettype none
`include "coef_defs.vh"
module eq_coefficient_access (
    // Clock and reset
    input  wire              clk,
    input  wire              reset,
    // Word register port
    input  wire              word_wr,
    input  wire              word_rd,
    input  wire [7:0]        word_addr,
    input  wire [15:0]       word_wdata,
    output reg  [15:0]       word_rdata_r,
    output reg               word_rvalid_r,
    // Byte register port
    input  wire              byte_wr,
    input  wire              byte_rd,
    input  wire [7:0]        byte_addr,
    input  wire [7:0]        byte_wdata,
    output reg  [7:0]        byte_rdata_r,
    output reg               byte_rvalid_r,
    output reg               store_busy_r,
    // Audio samples
    input  wire              six_channel,
    input  wire              sample_strobe,
    input  wire [`SMP_W-1:0] in_l,
    input  wire [`SMP_W-1:0] in_r,
    input  wire [`SMP_W-1:0] in_ls,
    input  wire [`SMP_W-1:0] in_rs,
    input  wire [`SMP_W-1:0] in_c,
    input  wire [`SMP_W-1:0] in_lfe,
    output reg  [`SMP_W-1:0] out_l_r,
    output reg  [`SMP_W-1:0] out_r_r,
    output reg  [`SMP_W-1:0] out_ls_r,
    output reg  [`SMP_W-1:0] out_rs_r,
    output reg  [`SMP_W-1:0] out_c_r,
    output reg  [`SMP_W-1:0] out_sub_r,
    output reg               out_valid_r,
    output reg               engine_busy_r
);
    localparam E_IDLE  = 3'd0;
    localparam E_RED   = 3'd1;
    localparam E_SCALE = 3'd2;
    localparam E_MAC   = 3'd3;
    localparam E_WB    = 3'd4;
    localparam E_DONE  = 3'd5;
    localparam J_L     = 3'd0;
    localparam J_R     = 3'd1;
    localparam J_LS    = 3'd2;
    localparam J_RS    = 3'd3;
    localparam J_SUB   = 3'd4;
    localparam D_X2    = 3'd1;
    localparam D_X     = 3'd2;
    localparam D_Y2    = 3'd3;
    localparam D_Y1    = 3'd4;
    localparam D_X1    = 3'd5;

    reg  [`REG_W-1:0]   data_r;
    reg  [`REG_W-1:0]   ctrl_r;
    reg  [`REG_W-1:0]   eq_r;
    reg  [`REG_W-1:0]   bass_r;
    reg                 fetch_r;
    reg                 init_r;
    reg  [6:0]          init_idx_r;
    reg  [7:0]          wa;
    reg                 wr_hi;
    reg                 wr_lo;
    reg  [15:0]         wd;
    reg                 ca_we;
    reg  [6:0]          ca_addr;
    reg  [`COEF_W-1:0]  ca_wdata;
    wire [`COEF_W-1:0]  ca_rdata;
    reg  [6:0]          cb_addr;
    wire [`COEF_W-1:0]  cb_rdata;
    reg                 h_we;
    reg  [6:0]          h_addr;
    reg  [`SMP_W-1:0]   h_wdata;
    wire [`SMP_W-1:0]   h_rdata;

    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input        hi;
        input        lo;
        merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
    endfunction

    function [15:0] read_mux;
        input [7:0] a;
        begin
            if (a == `A_DATA)
                read_mux = data_r;
            else if (a == `A_CTRL)
                read_mux = ctrl_r;
            else if (a == `A_EQ)
                read_mux = eq_r;
            else if (a == `A_BASS)
                read_mux = bass_r;
            else
                read_mux = `REG_RST;
        end
    endfunction

    function [`COEF_W-1:0] default_coef;
        input [6:0] idx;
        begin
            if (idx == `IDX_SUB0 || idx == `IDX_SUB4)
                default_coef = `DEF_SUB0;
            else if (idx == `IDX_SUB1)
                default_coef = `DEF_SUB1;
            else if (idx == `IDX_SUB2)
                default_coef = `DEF_SUB2;
            else if (idx == `IDX_SUB3)
                default_coef = `DEF_SUB3;
            else if ((idx >= `IDX_SCALE_LR && idx <= `IDX_SCALE_SUB) || idx == `IDX_RED_LFE)
                default_coef = `DEF_SCALE;
            else if (idx >= `IDX_RED && idx < `IDX_RED_LFE)
                default_coef = `DEF_RED;
            else
                default_coef = `DEF_ZERO;
        end
    endfunction

    // A word write wins over a byte write in the same cycle
    always @* begin
        wa    = {byte_addr[7:1], 1'b0};
        wr_hi = 1'b0;
        wr_lo = 1'b0;
        wd    = {byte_wdata, byte_wdata};
        if (word_wr) begin
            wa    = word_addr;
            wr_hi = 1'b1;
            wr_lo = 1'b1;
            wd    = word_wdata;
        end else if (byte_wr) begin
            wr_hi = ~byte_addr[0];
            wr_lo = byte_addr[0];
        end
    end

    wire        soft_rst = (wr_hi | wr_lo) && wa == `A_RESET;
    wire [15:0] ctrl_nxt = merge(ctrl_r, wd, wr_hi && wa == `A_CTRL, wr_lo && wa == `A_CTRL);
    wire        trigger  = wr_lo && wa == `A_CTRL && !init_r;
    wire [7:0]  tgt      = ctrl_nxt[15:8] - `IDX_BASE;
    wire        in_range = ctrl_nxt[15:8] >= `IDX_BASE && tgt < `COEF_N;
    wire        fetch_go = trigger && in_range && ctrl_nxt[`RD_BIT];
    wire [15:0] bword    = read_mux({byte_addr[7:1], 1'b0});

    always @* begin
        ca_we    = 1'b0;
        ca_addr  = tgt[6:0];
        ca_wdata = {ctrl_nxt[3:0], data_r};
        if (init_r) begin
            ca_we    = {1'b0, init_idx_r} < `COEF_N;
            ca_addr  = init_idx_r;
            ca_wdata = default_coef(init_idx_r);
        end else if (trigger && in_range) begin
            ca_we    = ~ctrl_nxt[`RD_BIT];
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            data_r       <= `REG_RST;
            ctrl_r       <= `REG_RST;
            eq_r         <= `REG_RST;
            bass_r       <= `REG_RST;
            fetch_r      <= 1'b0;
            init_r       <= 1'b1;
            init_idx_r   <= 7'd0;
            store_busy_r <= 1'b1;
        end else if (soft_rst) begin
            data_r       <= `REG_RST;
            ctrl_r       <= `REG_RST;
            eq_r         <= `REG_RST;
            bass_r       <= `REG_RST;
            fetch_r      <= 1'b0;
            init_r       <= 1'b1;
            init_idx_r   <= 7'd0;
            store_busy_r <= 1'b1;
        end else begin
            if (wa == `A_DATA)
                data_r <= merge(data_r, wd, wr_hi, wr_lo);
            if (wa == `A_EQ)
                eq_r <= merge(eq_r, wd, wr_hi, wr_lo);
            if (wa == `A_BASS)
                bass_r <= merge(bass_r, wd, wr_hi, wr_lo);
            ctrl_r  <= ctrl_nxt;
            fetch_r <= fetch_go;
            // Fetched data overrides a host write landing in the same cycle
            if (fetch_r) begin
                data_r      <= ca_rdata[15:0];
                ctrl_r[3:0] <= ca_rdata[`COEF_W-1:16];
            end
            if (init_r) begin
                init_idx_r <= init_idx_r + 7'd1;
                if (init_idx_r == `HIST_LAST)
                    init_r <= 1'b0;
            end
            store_busy_r <= (init_r && init_idx_r != `HIST_LAST) || fetch_go;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            word_rdata_r  <= `REG_RST;
            word_rvalid_r <= 1'b0;
            byte_rdata_r  <= 8'h00;
            byte_rvalid_r <= 1'b0;
        end else begin
            word_rvalid_r <= word_rd;
            byte_rvalid_r <= byte_rd;
            if (word_rd)
                word_rdata_r <= read_mux(word_addr);
            if (byte_rd)
                byte_rdata_r <= byte_addr[0] ? bword[7:0] : bword[15:8];
        end
    end

    // Coefficient store: host and init on port A, engine on port B
    dual_ram #(.W(`COEF_W), .D(`COEF_N), .AW(`COEF_AW)) u_coef (
        .clk     (clk),
        .a_we    (ca_we),
        .a_addr  (ca_addr),
        .a_wdata (ca_wdata),
        .a_rdata (ca_rdata),
        .b_addr  (cb_addr),
        .b_rdata (cb_rdata)
    );

    // Filter history, addressed {job, stage, slot}
    dual_ram #(.W(`SMP_W), .D(`HIST_N), .AW(`HIST_AW)) u_hist (
        .clk     (clk),
        .a_we    (h_we),
        .a_addr  (h_addr),
        .a_wdata (h_wdata),
        .a_rdata (h_rdata),
        .b_addr  (7'd0),
        .b_rdata ()
    );

    reg  [2:0]                e_state_r;
    reg  [2:0]                job_r;
    reg  [1:0]                stage_r;
    reg  [2:0]                t_r;
    reg  [`SMP_W-1:0]         smp_r [0:5];
    reg  [`SMP_W-1:0]         res_r [0:4];
    reg  [`SMP_W-1:0]         sub_r;
    reg  [`SMP_W-1:0]         cur_r;
    reg  [`SMP_W-1:0]         old_x1_r;
    reg  [`SMP_W-1:0]         old_y1_r;
    reg  signed [`ACC_W-1:0]  acc_r;
    reg  [`SMP_W-1:0]         job_in;
    reg  [6:0]                scale_idx;
    reg  [6:0]                grp;
    reg                       filt_en;
    reg  signed [`SMP_W-1:0]  mul_a;
    wire signed [`COEF_W-1:0] mul_b = cb_rdata;
    wire signed [`PROD_W-1:0] prod  = mul_a * mul_b;
    wire signed [`ACC_W-1:0]  pext  = {{(`ACC_W-`PROD_W){prod[`PROD_W-1]}}, prod};
    wire [2:0]                red_ch = t_r - 3'd1;
    wire [`SMP_W:0]           sdiff  = {smp_r[2][`SMP_W-1], smp_r[2]} - {smp_r[3][`SMP_W-1], smp_r[3]};
    wire [`SMP_W:0]           sdiff_n = -sdiff;
    wire                      eq_en = eq_r[`EQ_EN_BIT];
    wire                      sf_en = eq_r[`SF_EN_BIT];
    integer                   i;

    function [`SMP_W-1:0] sat;
        input [`ACC_W-1:0] v;
        reg   [`ACC_W-1:0] s;
        begin
            s = $signed(v) >>> `FRAC;
            if (&s[`ACC_W-1:`SMP_W-1] || ~|s[`ACC_W-1:`SMP_W-1])
                sat = s[`SMP_W-1:0];
            else if (s[`ACC_W-1])
                sat = `SMP_MIN;
            else
                sat = `SMP_MAX;
        end
    endfunction

    function [1:0] hist_slot;
        input [2:0] t;
        case (t)
            3'd0:    hist_slot = `SL_X2;
            3'd2:    hist_slot = `SL_Y2;
            3'd3:    hist_slot = `SL_Y1;
            default: hist_slot = `SL_X1;
        endcase
    endfunction

    always @* begin
        job_in    = smp_r[0];
        scale_idx = `IDX_SCALE_LR;
        grp       = `GRP_LR;
        filt_en   = eq_en;
        case (job_r)
            J_R:  job_in = smp_r[1];
            J_LS: begin
                job_in    = sf_en ? sdiff[`SMP_W:1] : smp_r[2];
                scale_idx = `IDX_SCALE_SUR;
                grp       = `GRP_SUR;
                filt_en   = eq_en | sf_en;
            end
            J_RS: begin
                job_in    = sf_en ? sdiff_n[`SMP_W:1] : smp_r[3];
                scale_idx = `IDX_SCALE_SUR;
                grp       = `GRP_SUR;
                filt_en   = eq_en | sf_en;
            end
            J_SUB: begin
                job_in    = sub_r;
                scale_idx = `IDX_SCALE_SUB;
                grp       = `GRP_SUB;
            end
            default: job_in = smp_r[0];
        endcase
    end

    always @* begin
        mul_a   = job_in;
        cb_addr = `IDX_RED + {4'b0000, t_r};
        h_we    = 1'b0;
        h_addr  = {job_r, stage_r, hist_slot(t_r)};
        h_wdata = cur_r;
        if (init_r) begin
            h_we    = 1'b1;
            h_addr  = init_idx_r;
            h_wdata = {`SMP_W{1'b0}};
        end
        if (e_state_r == E_RED) begin
            mul_a = smp_r[red_ch];
        end else if (e_state_r == E_SCALE) begin
            cb_addr = scale_idx;
        end else if (e_state_r == E_MAC) begin
            cb_addr = grp + `STAGE_TERMS * {5'b00000, stage_r} + {4'b0000, t_r};
            mul_a   = (t_r == D_X) ? cur_r : h_rdata;
        end else if (e_state_r == E_WB) begin
            h_we    = 1'b1;
            h_addr  = {job_r, stage_r, t_r[1:0]};
            case (t_r[1:0])
                `SL_X2:  h_wdata = old_x1_r;
                `SL_Y1:  h_wdata = sat(acc_r);
                `SL_Y2:  h_wdata = old_y1_r;
                default: h_wdata = cur_r;
            endcase
        end
    end

    task next_job;
        begin
            t_r <= 3'd0;
            if (job_r == J_SUB) begin
                e_state_r <= E_DONE;
            end else begin
                job_r     <= job_r + 3'd1;
                e_state_r <= E_SCALE;
            end
        end
    endtask

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            e_state_r <= E_IDLE;
            job_r <= 3'd0;
            stage_r <= 2'd0;
            t_r <= 3'd0;
            acc_r <= {`ACC_W{1'b0}};
            sub_r <= {`SMP_W{1'b0}};
            cur_r <= {`SMP_W{1'b0}};
            old_x1_r <= {`SMP_W{1'b0}};
            old_y1_r <= {`SMP_W{1'b0}};
            for (i = 0; i < 6; i = i + 1)
                smp_r[i] <= {`SMP_W{1'b0}};
            for (i = 0; i < 5; i = i + 1)
                res_r[i] <= {`SMP_W{1'b0}};
            out_l_r <= {`SMP_W{1'b0}};
            out_r_r <= {`SMP_W{1'b0}};
            out_ls_r <= {`SMP_W{1'b0}};
            out_rs_r <= {`SMP_W{1'b0}};
            out_c_r <= {`SMP_W{1'b0}};
            out_sub_r <= {`SMP_W{1'b0}};
            out_valid_r <= 1'b0;
            engine_busy_r <= 1'b0;
        end else begin
            out_valid_r <= 1'b0;
            case (e_state_r)
                E_IDLE: if (sample_strobe && !init_r) begin
                    smp_r[0] <= in_l;
                    smp_r[1] <= in_r;
                    smp_r[2] <= in_ls;
                    smp_r[3] <= in_rs;
                    // Four-channel input carries no centre or LFE
                    smp_r[4] <= six_channel ? in_c : {`SMP_W{1'b0}};
                    smp_r[5] <= six_channel ? in_lfe : {`SMP_W{1'b0}};
                    acc_r <= {`ACC_W{1'b0}};
                    job_r <= J_L;
                    t_r <= 3'd0;
                    engine_busy_r <= 1'b1;
                    e_state_r <= E_RED;
                end
                E_RED: begin
                    // LFE always feeds the subwoofer; the rest only when redirected
                    if (t_r != 3'd0 && (red_ch == 3'd5 || bass_r[`BASS_EN_BIT]))
                        acc_r <= acc_r - pext;
                    if (t_r == `RED_N)
                        e_state_r <= E_SCALE;
                    t_r <= (t_r == `RED_N) ? 3'd0 : t_r + 3'd1;
                end
                E_SCALE: begin
                    if (job_r == J_L && t_r == 3'd0)
                        sub_r <= sat(acc_r);
                    if (!filt_en) begin
                        res_r[job_r] <= job_in;
                        next_job;
                    end else if (t_r == 3'd0) begin
                        t_r <= 3'd1;
                    end else begin
                        cur_r <= sat(-pext);
                        stage_r <= 2'd0;
                        t_r <= 3'd0;
                        e_state_r <= E_MAC;
                    end
                end
                E_MAC: begin
                    case (t_r)
                        3'd0: acc_r <= {{(`ACC_W-`SMP_W){cur_r[`SMP_W-1]}}, cur_r} <<< `FRAC;
                        D_X2: acc_r <= acc_r + pext;
                        D_X:  acc_r <= acc_r + pext;
                        D_Y2: acc_r <= acc_r - pext;
                        D_Y1: begin
                            acc_r <= acc_r - (pext <<< 1);
                            old_y1_r <= h_rdata;
                        end
                        default: begin
                            acc_r <= acc_r + (pext <<< 1);
                            old_x1_r <= h_rdata;
                        end
                    endcase
                    if (t_r == `TERMS)
                        e_state_r <= E_WB;
                    t_r <= (t_r == `TERMS) ? 3'd0 : t_r + 3'd1;
                end
                E_WB: begin
                    if (t_r == `WB_LAST) begin
                        cur_r <= sat(acc_r);
                        t_r <= 3'd0;
                        if (stage_r == `STAGE_LAST) begin
                            res_r[job_r] <= sat(acc_r);
                            next_job;
                        end else begin
                            stage_r <= stage_r + 2'd1;
                            e_state_r <= E_MAC;
                        end
                    end else begin
                        t_r <= t_r + 3'd1;
                    end
                end
                E_DONE: begin
                    out_l_r <= res_r[0];
                    out_r_r <= res_r[1];
                    out_ls_r <= res_r[2];
                    out_rs_r <= res_r[3];
                    out_sub_r <= res_r[4];
                    out_c_r <= smp_r[4];
                    out_valid_r <= 1'b1;
                    engine_busy_r <= 1'b0;
                    e_state_r <= E_IDLE;
                end
                default: e_state_r <= E_IDLE;
            endcase
        end
    end
endmodule // eq_coefficient_access
`default_nettype wire

/* File: verif/eq_coefficient_access_checker.sv */
// Port-level assertions for the coefficient access block
`timescale 1ns/1ps
`default_nettype none
`include "coef_defs.vh"
module eq_coefficient_access_checker (
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // Word register port
    input wire logic              word_wr,
    input wire logic              word_rd,
    input wire logic [7:0]        word_addr,
    input wire logic [15:0]       word_wdata,
    input wire logic [15:0]       word_rdata_r,
    input wire logic              word_rvalid_r,
    input wire logic              byte_wr,
    input wire logic              store_busy_r,
    // Audio
    input wire logic              six_channel,
    input wire logic              sample_strobe,
    input wire logic [`SMP_W-1:0] out_c_r,
    input wire logic              out_valid_r,
    input wire logic              engine_busy_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Targets outside the store are neither stored nor fetched
    wire rtrig = word_wr && word_addr == `A_CTRL && word_wdata[`RD_BIT] && !store_busy_r
        && word_wdata[15:8] >= 8'h40 && word_wdata[15:8] <= 8'h84;
    a_word_rd_answer: assert property (word_rd |=> word_rvalid_r)
        else $error("word read not answered");
    a_rvalid_once: assert property (!word_rd |=> !word_rvalid_r)
        else $error("stray word read answer");
    a_rdata_held: assert property (!word_rd |=> $stable(word_rdata_r))
        else $error("read data moved without a read");
    a_fetch_busy: assert property (rtrig |=> store_busy_r ##1 !store_busy_r)
        else $error("fetch timing wrong");
    a_data_no_launch: assert property (word_wr && word_addr == `A_DATA && !byte_wr && !store_busy_r |=> !store_busy_r)
        else $error("data write launched a store access");
    a_frame_latency: assert property (sample_strobe && !engine_busy_r && !store_busy_r
        |=> engine_busy_r ##[13:218] out_valid_r) else $error("frame latency out of range");
    a_valid_once: assert property (out_valid_r |=> !out_valid_r)
        else $error("frame result held too long");
    a_four_ch_centre: assert property (out_valid_r && !six_channel |-> out_c_r == 24'h000000)
        else $error("centre present with four channels");
endmodule // eq_coefficient_access_checker
bind eq_coefficient_access eq_coefficient_access_checker chk_inst (.*);
`default_nettype wire

/* File: verif/coef_host.sv */
// Host model issuing word and byte register accesses
`timescale 1ns/1ps
`default_nettype none
module coef_host (
    // Clock
    input  wire logic        clk,
    // Requests
    output var  logic        word_wr,
    output var  logic        word_rd,
    output var  logic [7:0]  word_addr,
    output var  logic [15:0] word_wdata,
    output var  logic        byte_wr,
    output var  logic        byte_rd,
    output var  logic [7:0]  byte_addr,
    output var  logic [7:0]  byte_wdata,
    // Answers
    input  wire logic [15:0] word_rdata_r,
    input  wire logic [7:0]  byte_rdata_r
);
    initial {word_wr, word_rd, byte_wr, byte_rd, word_addr, byte_addr, word_wdata, byte_wdata} = '0;
    task automatic acc(input bit bp, input bit rd, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge clk);
        word_addr <= a;
        byte_addr <= a;
        word_wdata <= d;
        byte_wdata <= d[7:0];
        {word_wr, byte_wr, word_rd, byte_rd} <= {!bp && !rd, bp && !rd, !bp && rd, bp && rd};
        @(posedge clk);
        {word_wr, byte_wr, word_rd, byte_rd} <= 4'h0;
        word_addr <= ~a;
        byte_addr <= ~a;
        word_wdata <= ~d;
        @(posedge clk); // Spacing lets a fetch land before anything follows
        q = bp ? {8'h00, byte_rdata_r} : word_rdata_r;
    endtask
endmodule // coef_host
`default_nettype wire

/* File: verif/eq_coefficient_access_tb.sv */
// Self-checking bench for the coefficient access block
`timescale 1ns/1ps
`default_nettype none
`include "coef_defs.vh"
module eq_coefficient_access_tb;
    logic clk = 0, reset = 1, six_channel = 0, sample_strobe = 0, word_wr, word_rd, byte_wr, byte_rd;
    logic word_rvalid_r, byte_rvalid_r, store_busy_r, out_valid_r, engine_busy_r;
    logic [7:0] word_addr, byte_addr, byte_wdata, byte_rdata_r;
    logic [15:0] word_wdata, word_rdata_r, q;
    logic [19:0] v, w;
    logic [23:0] smp [6], res [6];
    int seed = 32'h1BFDE392, error_cnt = 0, num_checks = 0, cyc = 0;
    initial forever #12.5 clk = ~clk;
    coef_host h (.*);
    eq_coefficient_access eq_coefficient_access_inst (.*, .in_l(smp[0]), .in_r(smp[1]), .in_ls(smp[2]),
        .in_rs(smp[3]), .in_c(smp[4]), .in_lfe(smp[5]), .out_l_r(res[0]), .out_r_r(res[1]),
        .out_ls_r(res[2]), .out_rs_r(res[3]), .out_c_r(res[4]), .out_sub_r(res[5]));
    task automatic chk(input logic [23:0] g, input logic [23:0] x);
        num_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic settle; // Store clear takes 80 cycles
        for (int n = 0; n < 200 && store_busy_r !== 1'b0; n++) @(posedge clk);
    endtask
    task automatic cwr(input bit bp, input logic [6:0] i, input logic [19:0] x);
        if (bp) begin
            h.acc(1, 0, `A_DATA, {8'h00, x[15:8]}, q);
            h.acc(1, 0, 8'h79, {8'h00, x[7:0]}, q);
            h.acc(1, 0, `A_CTRL, {8'h00, `IDX_BASE + i}, q);
            h.acc(1, 0, 8'h7B, {12'h000, x[19:16]}, q);
        end else begin
            h.acc(0, 0, `A_DATA, x[15:0], q);
            h.acc(0, 0, `A_CTRL, {`IDX_BASE + i, 4'h0, x[19:16]}, q);
        end
    endtask
    task automatic crd(input bit bp, input logic [6:0] i, output logic [19:0] x);
        if (bp) h.acc(1, 0, `A_CTRL, {8'h00, `IDX_BASE + i}, q);
        h.acc(bp, 0, `A_CTRL | bp, {`IDX_BASE + i, 8'h10}, q);
        h.acc(bp, 1, `A_DATA, 16'h0000, q);
        x[15:0] = q;
        if (bp) begin
            h.acc(1, 1, 8'h79, 16'h0000, q);
            x[15:0] = {x[7:0], q[7:0]};
        end
        h.acc(bp, 1, `A_CTRL | bp, 16'h0000, q);
        x[19:16] = q[3:0];
    endtask
    function automatic logic [23:0] sub_exp(input int s [6], input bit bass, input bit sx);
        return 24'((sx ? s[5] : 0) + (bass ? (s[0] + s[1] + s[2] + s[3] + (sx ? s[4] : 0)) / 2 : 0));
    endfunction
    task automatic frame(input bit [3:0] m); // Mode is side-fire, eq, bass, six
        int s [6];
        h.acc(0, 0, `A_EQ, {14'h0000, m[3:2]}, q);
        h.acc(0, 0, `A_BASS, {15'h0000, m[1]}, q);
        six_channel <= m[0];
        sample_strobe <= 1'b1;
        foreach (s[k]) begin
            s[k] = ($random(seed) >>> 13) & -2; // Even and small, so halving is exact
            smp[k] <= 24'(s[k]);
        end
        @(posedge clk);
        sample_strobe <= 1'b0;
        for (int n = 0; n < 300 && out_valid_r !== 1'b1; n++) @(posedge clk);
        chk(out_valid_r, 1'b1);
        chk(res[0], m[2] ? 24'h0 : 24'(s[0]));
        chk(res[1], m[2] ? 24'h0 : 24'(s[1]));
        chk(res[2], 24'(m[3] ? (s[2] - s[3]) / 2 : s[2]));
        chk(res[3], 24'(m[3] ? (s[3] - s[2]) / 2 : s[3]));
        chk(res[4], m[0] ? 24'(s[4]) : 24'h0);
        if (!m[2]) chk(res[5], sub_exp(s, m[1], m[0]));
        $display("frame mode %h done", m);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            give_verdict;
        end
    end
    initial begin
        bit [3:0] md [6] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h5, 4'hB};
        foreach (smp[k]) smp[k] = 24'h000000;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        settle();
        crd(0, `IDX_RED_LFE, v);
        chk(v, `DEF_SCALE);
        repeat (4) begin
            w = $random(seed);
            v = 20'($unsigned($random(seed)) % 20);
            cwr(v[0], v[6:0], w);
            h.acc(0, 0, `A_DATA, ~w[15:0], q);
            crd(v[1], v[6:0], v);
            chk(v, w);
        end
        $display("coefficient access done");
        cwr(0, `IDX_SCALE_LR, 20'h00000);
        foreach (md[k]) frame(md[k]);
        h.acc(1, 0, `A_RESET, 16'h0000, q);
        settle();
        crd(1, `IDX_SCALE_LR, v);
        chk(v, `DEF_SCALE);
        h.acc(0, 1, `A_EQ, 16'h0000, q);
        chk(q, 24'h0);
        h.acc(0, 1, 8'h50, 16'h0000, q);
        chk(q, 24'h0);
        $display("soft reset done");
        give_verdict;
    end
endmodule // eq_coefficient_access_tb
`default_nettype wire
